// file: smos_pkg.sv
// Shared constants and types for the supply monitor output sequencer.
package smos_pkg;

    // Clock rate in kHz, period 100 ns.
    localparam int unsigned CLK_KHZ = 10_000;

    // Interval figures in microseconds; values are plain defaults.
    localparam int unsigned RESET_RELEASE_US = 64;
    localparam int unsigned UV_ENABLE_US     = 64;
    localparam int unsigned UV_DISABLE_US    = 64;
    localparam int unsigned OV_ENABLE_US     = 64;
    localparam int unsigned OV_DISABLE_US    = 64;
    localparam int unsigned POWER_ON_US      = 64;
    localparam int unsigned TEMPCOMP_US      = 64;

    // Least times round up to whole cycles.
    localparam int unsigned RESET_RELEASE_CYC = (RESET_RELEASE_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned UV_ENABLE_CYC     = (UV_ENABLE_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned UV_DISABLE_CYC    = (UV_DISABLE_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned OV_ENABLE_CYC     = (OV_ENABLE_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned OV_DISABLE_CYC    = (OV_DISABLE_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned POWER_ON_CYC      = (POWER_ON_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned TEMPCOMP_CYC      = (TEMPCOMP_US * CLK_KHZ + 999) / 1000;

    // Counter width; every count above fits.
    localparam int unsigned CNT_W = 12;

    // Number of synchronised comparator inputs and their bit positions.
    localparam int unsigned CMP_N      = 6;
    localparam int unsigned CMP_POR_HI = 0;
    localparam int unsigned CMP_POR_LO = 1;
    localparam int unsigned CMP_UV_EN  = 2;
    localparam int unsigned CMP_UV_DIS = 3;
    localparam int unsigned CMP_OV_EN  = 4;
    localparam int unsigned CMP_OV_DIS = 5;

    localparam logic [CMP_N-1:0] CMP_RST = 6'h00;

    // Output stage encoding driven to the analog driver.
    localparam logic [1:0] OUT_HIZ    = 2'h0;
    localparam logic [1:0] OUT_GROUND = 2'h1;
    localparam logic [1:0] OUT_MID    = 2'h2;

    typedef enum {
        SMOS_RESET,
        SMOS_RELEASE,
        SMOS_WAIT_UV,
        SMOS_RUN,
        SMOS_LOCKOUT,
        SMOS_OV_SHUT
    } smos_state_t;

endpackage : smos_pkg

// file: smos_sequencer.sv
// Supply supervision sequencer driving output stage and fault pin state.
`timescale 1ns/1ps

// How it works
// (R1) Hold reset until threshold and release interval.
// (R2) Release counter needs supply held above threshold.
// (R3) After release, wait undervoltage-disable interval, mid-scale.
// (R4) Power-down threshold reasserts reset, output high-z.
// (R5) Qualified undervoltage enters lockout, output grounded.
// (R6) Brief undervoltage dip keeps mid-scale output.
// (R7) Lockout ends after qualified undervoltage-disable interval.
// (R8) Power-down before lockout goes straight high-z.
// (R9) Lockout only works in 5 V variant.
// (R10) Qualified overvoltage shuts output to high-z.
// (R11) Fault pin high-z during overvoltage shutdown.
// (R12) Shutdown ends after qualified overvoltage-disable interval.
// (R13) Lock bit disables overvoltage detection entirely.
// (R14) Overvoltage detection stays available while unlocked.
// (R15) Tempcomp valid after power-on plus settle interval.
// (R16) Counters clear on deassert; reset, overvoltage, lockout priority.
// (R17) Comparator inputs pass two flip-flop synchroniser.
module smos_sequencer #(
    parameter int unsigned RELEASE_CYC = smos_pkg::RESET_RELEASE_CYC,
    parameter int unsigned UVE_CYC     = smos_pkg::UV_ENABLE_CYC,
    parameter int unsigned UVD_CYC     = smos_pkg::UV_DISABLE_CYC,
    parameter int unsigned OVE_CYC     = smos_pkg::OV_ENABLE_CYC,
    parameter int unsigned OVD_CYC     = smos_pkg::OV_DISABLE_CYC,
    parameter int unsigned PO_CYC      = smos_pkg::POWER_ON_CYC,
    parameter int unsigned TC_CYC      = smos_pkg::TEMPCOMP_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       above_power_up_i,
    input  wire logic       above_power_down_i,
    input  wire logic       below_uv_enable_i,
    input  wire logic       above_uv_disable_i,
    input  wire logic       above_ov_enable_i,
    input  wire logic       below_ov_disable_i,
    input  wire logic       variant_5v_i,
    input  wire logic       com_lock_i,
    output logic            internal_reset_o,
    output logic [1:0]      out_state_o,
    output logic            fault_pin_en_o,
    output logic            tempcomp_valid_o,
    output logic            uv_lockout_o,
    output logic            ov_shutdown_o
);

    localparam int unsigned W = smos_pkg::CNT_W;

    logic [smos_pkg::CMP_N-1:0] meta_ff;
    logic [smos_pkg::CMP_N-1:0] sync_ff;
    logic                       strap_5v_ff;
    logic                       variant_meta_ff;
    logic                       variant_ff;
    logic                       lock_ff;
    logic                       lock_meta_ff;
    smos_pkg::smos_state_t      state_ff;
    logic [W-1:0]               cnt_ff;
    logic [W-1:0]               tc_cnt_ff;
    logic                       ov_pend_ff;
    logic [W-1:0]               ov_cnt_ff;

    // (R17) Two-stage synchronisers.
    genvar g;
    logic [smos_pkg::CMP_N-1:0] raw;
    assign raw = {below_ov_disable_i, above_ov_enable_i, above_uv_disable_i,
                  below_uv_enable_i, above_power_down_i, above_power_up_i};
    generate
        for (g = 0; g < smos_pkg::CMP_N; g++) begin : g_sync
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    meta_ff[g] <= smos_pkg::CMP_RST[g];
                    sync_ff[g] <= smos_pkg::CMP_RST[g];
                end else begin
                    meta_ff[g] <= raw[g];
                    sync_ff[g] <= meta_ff[g];
                end
            end
        end
    endgenerate

    // Strap and lock bit come from pins, so both get the same two-stage synchroniser.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lock_meta_ff    <= 1'b0;
            lock_ff         <= 1'b0;
            variant_meta_ff <= 1'b0;
            variant_ff      <= 1'b0;
        end else begin
            lock_meta_ff    <= com_lock_i;
            lock_ff         <= lock_meta_ff;
            variant_meta_ff <= variant_5v_i;
            variant_ff      <= variant_meta_ff;
        end
    end

    logic por_hi;
    logic por_lo;
    logic uv_low;
    logic uv_ok;
    logic ov_high;
    logic ov_ok;
    logic ov_arm;
    assign por_hi  = sync_ff[smos_pkg::CMP_POR_HI];
    assign por_lo  = sync_ff[smos_pkg::CMP_POR_LO];
    assign uv_low  = sync_ff[smos_pkg::CMP_UV_EN];
    assign uv_ok   = sync_ff[smos_pkg::CMP_UV_DIS];
    assign ov_high = sync_ff[smos_pkg::CMP_OV_EN];
    assign ov_ok   = sync_ff[smos_pkg::CMP_OV_DIS];
    // (R13) Lock bit masks overvoltage. (R14) Unlocked keeps it live.
    assign ov_arm  = ov_high && !lock_ff;

    // (R9) Variant strap caught while held in reset state.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strap_5v_ff <= 1'b0;
        end else if (state_ff == smos_pkg::SMOS_RESET) begin
            strap_5v_ff <= variant_ff;
        end
    end

    // Main sequence and shared qualification counter.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= smos_pkg::SMOS_RESET;
            cnt_ff   <= '0;
        end else if (!por_lo && state_ff != smos_pkg::SMOS_RESET && state_ff != smos_pkg::SMOS_RELEASE) begin
            // (R4) Power-down reasserts reset. (R8) No lockout detour.
            state_ff <= smos_pkg::SMOS_RESET;
            cnt_ff   <= '0;
        end else begin
            case (state_ff)
                smos_pkg::SMOS_RESET: begin
                    cnt_ff <= '0;
                    // (R2) Release counter starts at power-up threshold.
                    if (por_hi) begin
                        state_ff <= smos_pkg::SMOS_RELEASE;
                    end
                end
                smos_pkg::SMOS_RELEASE: begin
                    // (R1) Release only after full interval above threshold.
                    if (!por_hi) begin
                        state_ff <= smos_pkg::SMOS_RESET;
                        cnt_ff   <= '0;
                    end else if (cnt_ff >= W'(RELEASE_CYC - 1)) begin
                        state_ff <= smos_pkg::SMOS_WAIT_UV;
                        cnt_ff   <= '0;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                smos_pkg::SMOS_WAIT_UV,
                smos_pkg::SMOS_LOCKOUT: begin
                    // (R3) Qualify undervoltage-disable. (R7) Exit lockout likewise.
                    if (ov_pend_ff) begin
                        state_ff <= smos_pkg::SMOS_OV_SHUT;
                        cnt_ff   <= '0;
                    end else if (!uv_ok) begin
                        cnt_ff <= '0;
                    end else if (cnt_ff >= W'(UVD_CYC - 1)) begin
                        state_ff <= smos_pkg::SMOS_RUN;
                        cnt_ff   <= '0;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                smos_pkg::SMOS_RUN: begin
                    // (R16) Overvoltage outranks lockout.
                    if (ov_pend_ff) begin
                        state_ff <= smos_pkg::SMOS_OV_SHUT;
                        cnt_ff   <= '0;
                    // (R5) Qualified dip locks out. (R6) Short dip clears count.
                    end else if (!(uv_low && strap_5v_ff)) begin
                        cnt_ff <= '0;
                    end else if (cnt_ff >= W'(UVE_CYC - 1)) begin
                        state_ff <= smos_pkg::SMOS_LOCKOUT;
                        cnt_ff   <= '0;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                smos_pkg::SMOS_OV_SHUT: begin
                    // (R12) Qualified drop ends shutdown; lock also ends it.
                    if (lock_ff) begin
                        state_ff <= smos_pkg::SMOS_RUN;
                        cnt_ff   <= '0;
                    end else if (!ov_ok) begin
                        cnt_ff <= '0;
                    end else if (cnt_ff >= W'(OVD_CYC - 1)) begin
                        state_ff <= smos_pkg::SMOS_RUN;
                        cnt_ff   <= '0;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                default: begin
                    state_ff <= smos_pkg::SMOS_RESET;
                    cnt_ff   <= '0;
                end
            endcase
        end
    end

    // (R10) Overvoltage enable qualification runs beside the main count.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ov_cnt_ff  <= '0;
            ov_pend_ff <= 1'b0;
        end else if (!ov_arm || state_ff == smos_pkg::SMOS_OV_SHUT || state_ff == smos_pkg::SMOS_RESET
                     || state_ff == smos_pkg::SMOS_RELEASE) begin
            ov_cnt_ff  <= '0;
            ov_pend_ff <= 1'b0;
        end else if (ov_cnt_ff >= W'(OVE_CYC - 1)) begin
            ov_pend_ff <= 1'b1;
        end else begin
            ov_cnt_ff <= ov_cnt_ff + 1'b1;
        end
    end

    // (R15) Power-on plus settle interval after release.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tc_cnt_ff        <= '0;
            tempcomp_valid_o <= 1'b0;
        end else if (state_ff == smos_pkg::SMOS_RESET || state_ff == smos_pkg::SMOS_RELEASE) begin
            tc_cnt_ff        <= '0;
            tempcomp_valid_o <= 1'b0;
        end else if (tc_cnt_ff >= W'(PO_CYC + TC_CYC - 1)) begin
            tempcomp_valid_o <= 1'b1;
        end else begin
            tc_cnt_ff <= tc_cnt_ff + 1'b1;
        end
    end

    // Registered outputs; the stage follows the state one cycle later.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            internal_reset_o <= 1'b1;
            out_state_o      <= smos_pkg::OUT_HIZ;
            fault_pin_en_o   <= 1'b0;
            uv_lockout_o     <= 1'b0;
            ov_shutdown_o    <= 1'b0;
        end else begin
            internal_reset_o <= (state_ff == smos_pkg::SMOS_RESET) || (state_ff == smos_pkg::SMOS_RELEASE);
            uv_lockout_o     <= state_ff == smos_pkg::SMOS_LOCKOUT;
            ov_shutdown_o    <= state_ff == smos_pkg::SMOS_OV_SHUT;
            // (R11) Fault pin released during shutdown.
            fault_pin_en_o   <= (state_ff == smos_pkg::SMOS_RUN) || (state_ff == smos_pkg::SMOS_LOCKOUT)
                                || (state_ff == smos_pkg::SMOS_WAIT_UV);
            case (state_ff)
                smos_pkg::SMOS_RUN:     out_state_o <= smos_pkg::OUT_MID;
                smos_pkg::SMOS_LOCKOUT: out_state_o <= smos_pkg::OUT_GROUND;
                default:                out_state_o <= smos_pkg::OUT_HIZ;
            endcase
        end
    end

    chk_pd_to_reset: assert property (@(posedge clk_i) disable iff (!arst_n_i) // (R4)
        (!por_lo && state_ff == smos_pkg::SMOS_RUN) |=> ##1 internal_reset_o && out_state_o == smos_pkg::OUT_HIZ)
        else $error("power-down did not reassert reset");
    chk_release_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i) // (R2)
        (state_ff == smos_pkg::SMOS_RELEASE && !por_hi && por_lo) |=> state_ff == smos_pkg::SMOS_RESET)
        else $error("release counter ignored supply drop");
    chk_wait_hiz: assert property (@(posedge clk_i) disable iff (!arst_n_i) // (R3)
        state_ff == smos_pkg::SMOS_WAIT_UV |=> out_state_o == smos_pkg::OUT_HIZ)
        else $error("output left high-z before undervoltage qualification");
    chk_lock_ground: assert property (@(posedge clk_i) disable iff (!arst_n_i) // (R5)
        state_ff == smos_pkg::SMOS_LOCKOUT |=> out_state_o == smos_pkg::OUT_GROUND)
        else $error("lockout did not ground output");
    chk_variant_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i) // (R9)
        !strap_5v_ff |-> state_ff != smos_pkg::SMOS_LOCKOUT)
        else $error("lockout entered in 3.3 V variant");
    chk_ov_fault_off: assert property (@(posedge clk_i) disable iff (!arst_n_i) // (R11)
        ov_shutdown_o |-> !fault_pin_en_o && out_state_o == smos_pkg::OUT_HIZ)
        else $error("fault pin active during shutdown");
    chk_lock_masks: assert property (@(posedge clk_i) disable iff (!arst_n_i) // (R13)
        lock_ff |=> !ov_pend_ff)
        else $error("overvoltage qualified while locked");
    chk_short_dip: assert property (@(posedge clk_i) disable iff (!arst_n_i) // (R6)
        (state_ff == smos_pkg::SMOS_RUN && !uv_low && !ov_pend_ff && por_lo) |=> cnt_ff == '0)
        else $error("enable count not cleared on recovery");
    chk_tc_after_rel: assert property (@(posedge clk_i) disable iff (!arst_n_i) // (R15)
        internal_reset_o |-> !tempcomp_valid_o)
        else $error("tempcomp valid while in reset");
    chk_ov_shut_hiz: assert property (@(posedge clk_i) disable iff (!arst_n_i) // (R10)
        state_ff == smos_pkg::SMOS_OV_SHUT |=> ov_shutdown_o && out_state_o == smos_pkg::OUT_HIZ)
        else $error("shutdown did not release output");
    chk_lockout_exit: assert property (@(posedge clk_i) disable iff (!arst_n_i) // (R7)
        (state_ff == smos_pkg::SMOS_LOCKOUT && por_lo && !ov_pend_ff && uv_ok && cnt_ff >= W'(UVD_CYC - 1))
        |=> state_ff == smos_pkg::SMOS_RUN) else $error("lockout did not end after qualified recovery");
    chk_fault_restore: assert property (@(posedge clk_i) disable iff (!arst_n_i) // (R12)
        (state_ff == smos_pkg::SMOS_OV_SHUT && por_lo && !lock_ff && ov_ok && cnt_ff >= W'(OVD_CYC - 1))
        |=> state_ff == smos_pkg::SMOS_RUN ##1 (fault_pin_en_o && out_state_o == smos_pkg::OUT_MID))
        else $error("shutdown exit did not restore output and fault pin");

    cov_lockout: cover property (@(posedge clk_i) disable iff (!arst_n_i) uv_lockout_o);
    cov_ov_shut: cover property (@(posedge clk_i) disable iff (!arst_n_i) ov_shutdown_o);
    cov_run:     cover property (@(posedge clk_i) disable iff (!arst_n_i) out_state_o == smos_pkg::OUT_MID);
    cov_tc:      cover property (@(posedge clk_i) disable iff (!arst_n_i) tempcomp_valid_o);
    cov_wait:    cover property (@(posedge clk_i) disable iff (!arst_n_i) state_ff == smos_pkg::SMOS_WAIT_UV);

endmodule : smos_sequencer

// file: smos_supply_model.sv
// Supply comparator model that turns a supply level in millivolts into threshold flags.
`timescale 1ns/1ps

module smos_supply_model #(
    parameter int unsigned POWER_DOWN_MV  = 2500,
    parameter int unsigned POWER_UP_MV    = 2800,
    parameter int unsigned UV_ENABLE_MV   = 4200,
    parameter int unsigned UV_DISABLE_MV  = 4400,
    parameter int unsigned OV_DISABLE_MV  = 5800,
    parameter int unsigned OV_ENABLE_MV   = 6000
) (
    input  wire logic [15:0] supply_mv_i,
    output logic             above_power_up_o,
    output logic             above_power_down_o,
    output logic             below_uv_enable_o,
    output logic             above_uv_disable_o,
    output logic             above_ov_enable_o,
    output logic             below_ov_disable_o
);
    // Hysteresis comes from the separate enable and disable levels, so each flag is a plain compare.
    assign above_power_up_o   = supply_mv_i >= 16'(POWER_UP_MV);
    assign above_power_down_o = supply_mv_i >= 16'(POWER_DOWN_MV);
    assign below_uv_enable_o  = supply_mv_i < 16'(UV_ENABLE_MV);
    assign above_uv_disable_o = supply_mv_i > 16'(UV_DISABLE_MV);
    assign above_ov_enable_o  = supply_mv_i > 16'(OV_ENABLE_MV);
    assign below_ov_disable_o = supply_mv_i < 16'(OV_DISABLE_MV);
endmodule : smos_supply_model

// file: supply_monitor_output_sequencer_test.sv
// Testbench comparing the supply sequencer with a zone-based reference model.
`timescale 1ns/1ps

module supply_monitor_output_sequencer_test;
    localparam int unsigned CYC        = 8;
    localparam int unsigned SETTLE     = 5 * CYC;
    localparam int          LO [0:6]   = '{0, 2600, 2900, 4250, 4500, 5850, 6100};
    localparam int          HI [0:6]   = '{2400, 2700, 4100, 4300, 5700, 5950, 7000};

    logic        clk_i;
    logic        arst_n_i;
    logic [15:0] supply_mv;
    logic        variant_5v;
    logic        com_lock;
    logic        a_pu, a_pd, b_uve, a_uvd, a_ove, b_ovd;
    logic        internal_reset_o, fault_pin_en_o, tempcomp_valid_o, uv_lockout_o, ov_shutdown_o;
    logic [1:0]  out_state_o;
    int          err_total;
    int          checked;
    int          m_st;
    int          m_v;
    int          uv_cnt;
    int          uv_mark;

    smos_supply_model supply (.supply_mv_i(supply_mv), .above_power_up_o(a_pu), .above_power_down_o(a_pd),
        .below_uv_enable_o(b_uve), .above_uv_disable_o(a_uvd), .above_ov_enable_o(a_ove),
        .below_ov_disable_o(b_ovd));

    smos_sequencer #(.RELEASE_CYC(CYC), .UVE_CYC(CYC), .UVD_CYC(CYC), .OVE_CYC(CYC), .OVD_CYC(CYC),
        .PO_CYC(CYC), .TC_CYC(CYC)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .above_power_up_i(a_pu),
        .above_power_down_i(a_pd), .below_uv_enable_i(b_uve), .above_uv_disable_i(a_uvd),
        .above_ov_enable_i(a_ove), .below_ov_disable_i(b_ovd), .variant_5v_i(variant_5v),
        .com_lock_i(com_lock), .internal_reset_o(internal_reset_o), .out_state_o(out_state_o),
        .fault_pin_en_o(fault_pin_en_o), .tempcomp_valid_o(tempcomp_valid_o),
        .uv_lockout_o(uv_lockout_o), .ov_shutdown_o(ov_shutdown_o));

    always #50 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (uv_lockout_o === 1'b1) uv_cnt++;
    end

    task automatic test_done();
        if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task automatic compare(input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : compare

    // States: 0 reset, 1 waiting for the disable level, 2 mid-scale, 3 lockout, 4 shutdown.
    function automatic void model(input int z);
        repeat (4) begin
            if (z == 0) begin
                m_st = 0;
                m_v  = int'(variant_5v);
            end
            else case (m_st)
                0: if (z >= 2) m_st = 1;
                1: if (z >= 4) m_st = 2;
                2: if (com_lock == 1'b0 && z == 6) m_st = 4;
                   else if (m_v == 1 && z <= 2) m_st = 3;
                3: if (z >= 4) m_st = 2;
                default: if (com_lock == 1'b1 || z <= 4) m_st = 2;
            endcase
        end
    endfunction : model

    task automatic check_all();
        logic [1:0] exp_out;
        @(negedge clk_i);
        exp_out = (m_st == 2) ? smos_pkg::OUT_MID : (m_st == 3) ? smos_pkg::OUT_GROUND : smos_pkg::OUT_HIZ;
        compare({2'h0, out_state_o}, {2'h0, exp_out});
        compare({3'h0, internal_reset_o}, {3'h0, m_st == 0});
        compare({3'h0, fault_pin_en_o}, {3'h0, m_st inside {1, 2, 3}});
        compare({3'h0, uv_lockout_o}, {3'h0, m_st == 3});
        compare({3'h0, ov_shutdown_o}, {3'h0, m_st == 4});
    endtask : check_all

    task automatic apply(input int z, input int n);
        @(posedge clk_i);
        supply_mv <= 16'($urandom_range(HI[z], LO[z]));
        repeat (n) @(posedge clk_i);
    endtask : apply

    task automatic go(input int z);
        apply(z, SETTLE);
        model(z);
        check_all();
    endtask : go

    task automatic set_lock(input logic v);
        @(posedge clk_i);
        com_lock <= v;
    endtask : set_lock

    initial begin
        #2_000_000;
        err_total++;
        test_done();
    end

    initial begin
        clk_i = 1'b0;
        arst_n_i = 1'b0;
        supply_mv = 16'h0000;
        variant_5v = 1'b0;
        com_lock = 1'b0;
        {err_total, checked, m_st, m_v, uv_cnt, uv_mark} = '0;
        void'($urandom(32'h0000_99ff));
        repeat (8) @(posedge clk_i);
        arst_n_i <= 1'b1;
        for (int v = 0; v < 2; v++) begin
            @(posedge clk_i);
            variant_5v <= v[0];
            go(0);
            apply(2, 3);
            go(1);
            apply(4, 4);
            @(negedge clk_i);
            compare({3'h0, tempcomp_valid_o}, 4'h0);
            go(4);
            compare({3'h0, tempcomp_valid_o}, 4'h1);
            go(0);
            go(3);
            go(4);
            apply(2, 3);
            go(4);
            go(2);
            go(3);
            go(4);
            go(6);
            go(5);
            go(4);
            set_lock(1'b1);
            go(6);
            set_lock(1'b0);
            go(6);
            set_lock(1'b1);
            go(6);
            set_lock(1'b0);
            go(4);
            apply(2, 3);
            uv_mark = uv_cnt;
            go(0);
            compare({3'h0, uv_cnt == uv_mark}, 4'h1);
        end
        go(4);
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        m_st = 0;
        check_all();
        @(posedge clk_i);
        arst_n_i <= 1'b1;
        go(4);
        test_done();
    end
endmodule : supply_monitor_output_sequencer_test
